/* core/ssviu_pkg.sv */
// Shared constants and types for the six-source vectored interrupt unit
package ssviu_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_PRIORITY = 10'h0_0f9;
    localparam logic [9:0] IDX_REQUEST = 10'h0_0fa;
    localparam logic [9:0] IDX_MASK = 10'h0_0fb;
    localparam logic [9:0] IDX_SRC_CFG = 10'h0_0fc;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h0_0fd;
    localparam logic [9:0] IDX_EVT_MASK = 10'h0_0fe;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int NUM_REQ = 6;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int EDGE_HI_BIT = 7;
    localparam int EDGE_LO_BIT = 6;
    localparam int PRI_GRP_A_BIT = 5;
    localparam int PRI_GRP_B_BIT = 2;
    localparam int PRI_GRP_C_BIT = 1;
    localparam int PRI_ORD_HI_BIT = 4;
    localparam int PRI_ORD_MID_BIT = 3;
    localparam int PRI_ORD_LO_BIT = 0;
    // Source configuration register fields
    localparam int CFG_UART_RX_EN = 0;
    localparam int CFG_UART_TX_SEL = 1;
    localparam int CFG_UART_BAUD_SEL = 2;
    localparam int CFG_PORT3_ANALOG = 3;
    localparam int CFG_STOP_REC_EN = 4;
    localparam int CFG_W = 5;
    // Synchronised pin inputs
    localparam int PIN_PORT3_1 = 0;
    localparam int PIN_PORT3_2 = 1;
    localparam int PIN_PORT3_3 = 2;
    localparam int PIN_CMP1 = 3;
    localparam int PIN_CMP2 = 4;
    localparam int NUM_PIN = 5;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Order codes for the three request groups
    localparam logic [2:0] ORD_CAB = 3'h1;
    localparam logic [2:0] ORD_ABC = 3'h2;
    localparam logic [2:0] ORD_ACB = 3'h3;
    localparam logic [2:0] ORD_BCA = 3'h4;
    localparam logic [2:0] ORD_CBA = 3'h5;
    localparam logic [2:0] ORD_BAC = 3'h6;

    typedef struct packed {
        logic [NUM_PIN-1:0] s1;
        logic [NUM_PIN-1:0] s2;
        logic [NUM_PIN-1:0] s3;
        logic [NUM_PIN-1:0] filt;
        logic [7:0] priority_reg;
        logic [7:0] request_reg;
        logic [7:0] mask_reg;
        logic [CFG_W-1:0] src_cfg;
        logic [NUM_REQ-1:0] evt_status;
        logic [NUM_REQ-1:0] evt_mask;
        logic in_service;
        logic core_req;
        logic [7:0] vec_loc;
        logic [31:0] rdata;
        logic slverr;
    } ssviu_state_type;

    typedef struct packed {
        logic valid;
        logic [2:0] id;
    } ssviu_pick_type;

endpackage

/* core/ssviu_top.sv */
// Six-source vectored interrupt unit with APB register access
`timescale 1ns/10ps
`default_nettype none

module ssviu_top #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port3_pin1,
    input wire logic port3_pin2,
    input wire logic port3_pin3,
    input wire logic comparator_input_1,
    input wire logic comparator_input_2,
    input wire logic uart_rx_event,
    input wire logic uart_tx_event,
    input wire logic baud_rate_generator_event,
    input wire logic stop_recovery_event,
    input wire logic timer_16bit_event,
    input wire logic timer_8bit_event,
    input wire logic low_voltage_event,
    output logic core_request,
    output logic [7:0] core_vector_loc,
    input wire logic core_grant_ack,
    input wire logic core_cycle_done,
    output logic irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 12)
    begin : g_bad_addr
        $error("ADDR_W must be at least 12");
    end

    // ------------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------------
    // Reserved order codes fall back to A > B > C so the encoder never stalls
    function automatic ssviu_pkg::ssviu_pick_type ssviu_pick(
        input logic [5:0] act,
        input logic [7:0] pri
    );
        logic [2:0] grp [3][2];
        logic [1:0] ord [3];
        logic [2:0] code;
        ssviu_pkg::ssviu_pick_type res;
        grp[0][0] = pri[ssviu_pkg::PRI_GRP_A_BIT] ? 3'h3 : 3'h5;
        grp[0][1] = pri[ssviu_pkg::PRI_GRP_A_BIT] ? 3'h5 : 3'h3;
        grp[1][0] = pri[ssviu_pkg::PRI_GRP_B_BIT] ? 3'h0 : 3'h2;
        grp[1][1] = pri[ssviu_pkg::PRI_GRP_B_BIT] ? 3'h2 : 3'h0;
        grp[2][0] = pri[ssviu_pkg::PRI_GRP_C_BIT] ? 3'h4 : 3'h1;
        grp[2][1] = pri[ssviu_pkg::PRI_GRP_C_BIT] ? 3'h1 : 3'h4;
        code = {pri[ssviu_pkg::PRI_ORD_HI_BIT],
                pri[ssviu_pkg::PRI_ORD_MID_BIT],
                pri[ssviu_pkg::PRI_ORD_LO_BIT]};
        case (code)
            ssviu_pkg::ORD_CAB: ord = '{2'd2, 2'd0, 2'd1};
            ssviu_pkg::ORD_ABC: ord = '{2'd0, 2'd1, 2'd2};
            ssviu_pkg::ORD_ACB: ord = '{2'd0, 2'd2, 2'd1};
            ssviu_pkg::ORD_BCA: ord = '{2'd1, 2'd2, 2'd0};
            ssviu_pkg::ORD_CBA: ord = '{2'd2, 2'd1, 2'd0};
            ssviu_pkg::ORD_BAC: ord = '{2'd1, 2'd0, 2'd2};
            default: ord = '{2'd0, 2'd1, 2'd2};
        endcase
        res = '0;
        // Walk from lowest rank upward so the highest rank is written last
        for (int k = 5; k >= 0; k--)
        begin
            if (act[grp[ord[k/2]][k%2]])
            begin
                res.valid = 1'b1;
                res.id = grp[ord[k/2]][k%2];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // State and next-state logic
    // ------------------------------------------------------------------
    ssviu_pkg::ssviu_state_type s;
    ssviu_pkg::ssviu_state_type next_s;
    logic [ssviu_pkg::NUM_PIN-1:0] pins;
    logic [ssviu_pkg::NUM_PIN-1:0] agree;
    logic [ssviu_pkg::NUM_PIN-1:0] rise;
    logic [ssviu_pkg::NUM_PIN-1:0] fall;
    logic [5:0] hw_set;
    logic [5:0] ack_clr;
    logic [5:0] eligible;
    logic [9:0] idx;
    logic setup_ph;
    logic wr;
    logic mapped;
    logic ack;
    logic analog;
    logic e2_rise;
    logic e2_fall;
    logic e0_rise;
    logic e0_fall;
    logic [7:0] edge_sel;
    ssviu_pkg::ssviu_pick_type win;

    assign pins = {comparator_input_2, comparator_input_1, port3_pin3,
                   port3_pin2, port3_pin1};

    always_comb
    begin
        next_s = s;
        // Three-flop synchroniser; level taken once stages two and three agree
        next_s.s1 = pins;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        agree = ~(s.s2 ^ s.s3);
        rise = agree & s.s3 & ~s.filt;
        fall = agree & ~s.s3 & s.filt;
        next_s.filt = (agree & s.s3) | (~agree & s.filt);

        // Source selection and edge qualification
        analog = s.src_cfg[ssviu_pkg::CFG_PORT3_ANALOG];
        edge_sel = s.request_reg;
        e2_rise = analog ? rise[ssviu_pkg::PIN_CMP1]
            : rise[ssviu_pkg::PIN_PORT3_1];
        e2_fall = analog ? fall[ssviu_pkg::PIN_CMP1]
            : fall[ssviu_pkg::PIN_PORT3_1];
        e0_rise = analog ? rise[ssviu_pkg::PIN_CMP2]
            : rise[ssviu_pkg::PIN_PORT3_2];
        e0_fall = analog ? fall[ssviu_pkg::PIN_CMP2]
            : fall[ssviu_pkg::PIN_PORT3_2];
        hw_set = '0;
        hw_set[2] = (e2_rise & edge_sel[ssviu_pkg::EDGE_HI_BIT])
            | (e2_fall & (~edge_sel[ssviu_pkg::EDGE_HI_BIT]
                          | edge_sel[ssviu_pkg::EDGE_LO_BIT]));
        if (s.src_cfg[ssviu_pkg::CFG_UART_RX_EN])
        begin
            hw_set[0] = uart_rx_event;
        end
        else
        begin
            hw_set[0] = (e0_rise & edge_sel[ssviu_pkg::EDGE_LO_BIT])
                | (e0_fall & (~edge_sel[ssviu_pkg::EDGE_LO_BIT]
                              | edge_sel[ssviu_pkg::EDGE_HI_BIT]));
        end
        if (!analog && !s.src_cfg[ssviu_pkg::CFG_STOP_REC_EN])
        begin
            hw_set[1] = fall[ssviu_pkg::PIN_PORT3_3];
        end
        else
        begin
            hw_set[1] = stop_recovery_event;
        end
        if (s.src_cfg[ssviu_pkg::CFG_UART_TX_SEL])
        begin
            hw_set[1] = hw_set[1] | uart_tx_event;
        end
        else if (s.src_cfg[ssviu_pkg::CFG_UART_BAUD_SEL])
        begin
            hw_set[1] = hw_set[1] | baud_rate_generator_event;
        end
        hw_set[3] = timer_16bit_event;
        hw_set[4] = timer_8bit_event;
        hw_set[5] = low_voltage_event;

        // APB decode
        idx = paddr[11:2];
        mapped = (paddr[1:0] == 2'b00) && ((paddr >> 12) == '0)
            && (idx >= ssviu_pkg::IDX_PRIORITY)
            && (idx <= ssviu_pkg::IDX_EVT_MASK);
        setup_ph = psel & ~penable;
        wr = psel & penable & pwrite & mapped;
        if (setup_ph)
        begin
            next_s.slverr = ~mapped;
            next_s.rdata = ssviu_pkg::RST_WORD;
            case (idx)
                ssviu_pkg::IDX_REQUEST: next_s.rdata[7:0] = s.request_reg;
                ssviu_pkg::IDX_MASK: next_s.rdata[7:0] = s.mask_reg;
                ssviu_pkg::IDX_SRC_CFG:
                    next_s.rdata[ssviu_pkg::CFG_W-1:0] = s.src_cfg;
                ssviu_pkg::IDX_EVT_STATUS: next_s.rdata[5:0] = s.evt_status;
                ssviu_pkg::IDX_EVT_MASK: next_s.rdata[5:0] = s.evt_mask;
                // Priority register is write-only and reads as zero
                default: next_s.rdata = ssviu_pkg::RST_WORD;
            endcase
        end
        if (wr && idx == ssviu_pkg::IDX_PRIORITY)
        begin
            next_s.priority_reg = pwdata[7:0];
        end
        if (wr && idx == ssviu_pkg::IDX_MASK)
        begin
            next_s.mask_reg = pwdata[7:0];
        end
        if (wr && idx == ssviu_pkg::IDX_SRC_CFG)
        begin
            next_s.src_cfg = pwdata[ssviu_pkg::CFG_W-1:0];
        end
        if (wr && idx == ssviu_pkg::IDX_EVT_MASK)
        begin
            next_s.evt_mask = pwdata[5:0];
        end

        // Grant acknowledge starts the machine cycle
        ack = core_grant_ack & s.core_req;
        ack_clr = '0;
        if (ack)
        begin
            ack_clr[s.vec_loc[3:1]] = 1'b1;
            next_s.in_service = 1'b1;
            next_s.mask_reg[ssviu_pkg::GLOBAL_EN_BIT] = 1'b0;
        end
        else if (core_cycle_done)
        begin
            next_s.in_service = 1'b0;
        end

        // Pending bits: software write, then service clear, hardware set wins
        if (wr && idx == ssviu_pkg::IDX_REQUEST)
        begin
            next_s.request_reg = pwdata[7:0];
        end
        next_s.request_reg[5:0] = (next_s.request_reg[5:0] & ~ack_clr)
            | hw_set;

        // Event status: write one clears, a new grant in the same cycle wins
        if (wr && idx == ssviu_pkg::IDX_EVT_STATUS)
        begin
            next_s.evt_status = s.evt_status & ~pwdata[5:0];
        end
        next_s.evt_status = next_s.evt_status | ack_clr;

        // Arbitration on the updated pending and mask state
        eligible = next_s.request_reg[5:0] & next_s.mask_reg[5:0]
            & {6{next_s.mask_reg[ssviu_pkg::GLOBAL_EN_BIT]}};
        win = ssviu_pick(eligible, next_s.priority_reg);
        next_s.core_req = win.valid & ~next_s.in_service;
        if (win.valid)
        begin
            next_s.vec_loc = {4'h0, win.id, 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = s.rdata;
    assign pslverr = s.slverr & psel & penable;
    assign core_request = s.core_req;
    assign core_vector_loc = s.vec_loc;
    assign irq = |(s.evt_status & s.evt_mask);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_timer16_pending: assert property (
        timer_16bit_event |=> s.request_reg[3])
        else $error("timer event did not set pending bit 3");
    a_masked_recording: assert property (
        (low_voltage_event && !s.mask_reg[5]) |=> s.request_reg[5])
        else $error("masked request not recorded");
    a_grant_needs_enable: assert property (core_request |->
        s.mask_reg[core_vector_loc[3:1]]
        && s.mask_reg[ssviu_pkg::GLOBAL_EN_BIT])
        else $error("request shown with disabled line");
    a_no_req_in_service: assert property (
        s.in_service |-> !core_request)
        else $error("request shown during machine cycle");
    a_ack_disables: assert property (
        (core_grant_ack && core_request) |=>
        !s.mask_reg[ssviu_pkg::GLOBAL_EN_BIT] && s.in_service
        && !core_request)
        else $error("grant did not start machine cycle");
    a_ack_clears: assert property (
        (core_grant_ack && core_request && !timer_16bit_event
        && core_vector_loc == 8'h06) |=> !s.request_reg[3])
        else $error("serviced request not cleared");
    a_vector_even: assert property (
        core_request |-> core_vector_loc[0] == 1'b0
        && core_vector_loc <= 8'h0a)
        else $error("vector location out of range");
    // A rising pin level must never count as a request 1 edge
    a_pin3_falling: assert property (
        (!s.src_cfg[ssviu_pkg::CFG_PORT3_ANALOG]
        && !s.src_cfg[ssviu_pkg::CFG_STOP_REC_EN]
        && !s.src_cfg[ssviu_pkg::CFG_UART_TX_SEL]
        && !s.src_cfg[ssviu_pkg::CFG_UART_BAUD_SEL] && !s.request_reg[1]
        && rise[ssviu_pkg::PIN_PORT3_3] && !(psel && penable && pwrite))
        |=> !s.request_reg[1])
        else $error("rising edge on pin 3 raised request 1");
    a_rx_blocks_pin: assert property (
        (s.src_cfg[ssviu_pkg::CFG_UART_RX_EN] && !uart_rx_event
        && !s.request_reg[0] && !(psel && penable && pwrite)) |=>
        !s.request_reg[0])
        else $error("pin raised request 0 with receiver on");
    a_group_priority: assert property (
        (eligible == 6'b10_0011 && next_s.priority_reg[4:0] == 5'h01
        && !next_s.in_service) |=> core_request && core_vector_loc == 8'h02)
        else $error("group order C > A > B not kept");
    a_req2_rise_only: assert property (
        (!s.src_cfg[ssviu_pkg::CFG_PORT3_ANALOG]
        && s.request_reg[ssviu_pkg::EDGE_HI_BIT]
        && !s.request_reg[ssviu_pkg::EDGE_LO_BIT] && !s.request_reg[2]
        && fall[ssviu_pkg::PIN_PORT3_1] && !(psel && penable && pwrite))
        |=> !s.request_reg[2])
        else $error("falling edge raised request 2 in rise mode");

endmodule

`default_nettype wire

/* testbench/ssviu_core_model.sv */
// Behavioural processor core that grants requests and ends machine cycles
`timescale 1ns/10ps
`default_nettype none

module ssviu_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_request,
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    output logic core_grant_ack,
    output logic core_cycle_done
);
    logic [3:0] wait_cnt;
    logic [1:0] svc_cnt;
    logic busy;

    // Ack is a one-cycle pulse; done follows a fixed service time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt <= 4'h0;
            svc_cnt <= 2'h0;
            busy <= 1'b0;
            core_grant_ack <= 1'b0;
            core_cycle_done <= 1'b0;
        end
        else
        begin
            core_grant_ack <= 1'b0;
            core_cycle_done <= 1'b0;
            if (busy)
            begin
                if (svc_cnt == 2'h0)
                begin
                    core_cycle_done <= 1'b1;
                    busy <= 1'b0;
                end
                else
                    svc_cnt <= svc_cnt - 2'h1;
            end
            else if (core_request && ack_en && !core_grant_ack)
            begin
                // Slow answers come from a larger ack_delay
                if (wait_cnt == ack_delay)
                begin
                    core_grant_ack <= 1'b1;
                    busy <= 1'b1;
                    svc_cnt <= 2'h3;
                    wait_cnt <= 4'h0;
                end
                else
                    wait_cnt <= wait_cnt + 4'h1;
            end
            else
                wait_cnt <= 4'h0;
        end
    end
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking testbench for the six-source vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam logic [11:0] A_PRI = {ssviu_pkg::IDX_PRIORITY, 2'b00};
    localparam logic [11:0] A_REQ = {ssviu_pkg::IDX_REQUEST, 2'b00};
    localparam logic [11:0] A_MSK = {ssviu_pkg::IDX_MASK, 2'b00};
    localparam logic [11:0] A_CFG = {ssviu_pkg::IDX_SRC_CFG, 2'b00};
    localparam logic [11:0] A_EST = {ssviu_pkg::IDX_EVT_STATUS, 2'b00};
    localparam logic [11:0] A_EMK = {ssviu_pkg::IDX_EVT_MASK, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, core_request, irq, ack, done;
    logic [7:0] vec;
    logic [4:0] pin = 5'h00;
    logic [6:0] ev = 7'h00;
    logic ack_en = 1'b0;
    logic [31:0] rdv;
    logic err;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    // Winners with all six pending: plain codes, then inner bits set
    logic [7:0] pri_tab [14] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h10, 8'h11,
        8'h18, 8'h26, 8'h27, 8'h2e, 8'h2f, 8'h36, 8'h37, 8'h3e};
    logic [7:0] vec_tab [14] = '{8'h0a, 8'h02, 8'h0a, 8'h0a, 8'h04, 8'h02,
        8'h04, 8'h06, 8'h08, 8'h06, 8'h06, 8'h00, 8'h08, 8'h00};
    // Source config, event index, expected pending byte
    logic [4:0] ev_cfg [10] = '{5'h01, 5'h00, 5'h02, 5'h04, 5'h06, 5'h10,
        5'h00, 5'h00, 5'h00, 5'h00};
    int ev_idx [10] = '{0, 0, 1, 2, 2, 3, 3, 4, 5, 6};
    logic [7:0] ev_exp [10] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h00, 8'h02,
        8'h00, 8'h08, 8'h10, 8'h20};

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    ssviu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port3_pin1(pin[0]), .port3_pin2(pin[1]), .port3_pin3(pin[2]),
        .comparator_input_1(pin[3]), .comparator_input_2(pin[4]),
        .uart_rx_event(ev[0]), .uart_tx_event(ev[1]),
        .baud_rate_generator_event(ev[2]), .stop_recovery_event(ev[3]),
        .timer_16bit_event(ev[4]), .timer_8bit_event(ev[5]),
        .low_voltage_event(ev[6]), .core_request(core_request),
        .core_vector_loc(vec), .core_grant_ack(ack),
        .core_cycle_done(done), .irq(irq));

    ssviu_core_model core (.pclk(pclk), .presetn(presetn),
        .core_request(core_request), .ack_en(ack_en), .ack_delay(4'h5),
        .core_grant_ack(ack), .core_cycle_done(done));

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", n, 32'h0000_0001);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
        input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rdv, {24'h00_0000, e});
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("request reset", A_REQ, 8'h00);
        rdc("mask reset", A_MSK, 8'h00);
        rdc("priority read", A_PRI, 8'h00);
        rdc("unmapped", 12'h3fc, 8'h00);
        chk("unmapped err", err, 1'b1);
        wr(12'h3e9, 8'hff);
        chk("misaligned err", err, 1'b1);
        rdc("mapped err", A_CFG, 8'h00);
        chk("mapped err", err, 1'b0);
        // Edge select codes on the three port pins, polled with mask off
        for (int c = 0; c < 4; c++)
        begin
            wr(A_REQ, {c[1:0], 6'h00});
            pin <= 5'h07;
            repeat (8) @(posedge pclk);
            rdc("rise", A_REQ, {c[1:0], 3'h0, c[1], 1'b0, c[0]});
            wr(A_REQ, {c[1:0], 6'h00});
            pin <= 5'h00;
            repeat (8) @(posedge pclk);
            rdc("fall", A_REQ, {c[1:0], 3'h0, !c[1] | c == 3, 1'b1,
                !c[0] | c == 3});
        end
        // Receiver enabled and analog mode: pins 2 and 3 are out, comparator in
        wr(A_CFG, 8'h09);
        wr(A_REQ, 8'hc0);
        pin <= 5'h0e;
        repeat (8) @(posedge pclk);
        pin <= 5'h08;
        repeat (8) @(posedge pclk);
        rdc("analog route", A_REQ, 8'hc4);
        chk("masked no request", core_request, 1'b0);
        pin <= 5'h00;
        // Internal and shared sources, recorded while masked
        for (int i = 0; i < 10; i++)
        begin
            wr(A_CFG, {3'h0, ev_cfg[i]});
            wr(A_REQ, 8'h00);
            ev <= 7'h01 << ev_idx[i];
            @(posedge pclk);
            ev <= 7'h00;
            repeat (2) @(posedge pclk);
            rdc("source route", A_REQ, ev_exp[i]);
            chk("polled no request", core_request, 1'b0);
        end
        wr(A_CFG, 8'h00);
        // Every group order and in-group choice, all six pending
        for (int i = 0; i < 14; i++)
        begin
            wr(A_PRI, pri_tab[i]);
            wr(A_REQ, 8'h3f);
            wr(A_MSK, 8'hbf);
            repeat (2) @(posedge pclk);
            chk("request up", core_request, 1'b1);
            chk("vector", vec, vec_tab[i]);
            wr(A_MSK, 8'h3f);
            repeat (2) @(posedge pclk);
            chk("global off", core_request, 1'b0);
            wr(A_REQ, 8'h00);
        end
        // Requests 5, 1 and 0 under order C > A > B: request 1 wins
        wr(A_PRI, 8'h01);
        wr(A_REQ, 8'h23);
        wr(A_MSK, 8'hbf);
        repeat (2) @(posedge pclk);
        chk("group C request", core_request, 1'b1);
        chk("group C vector", vec, 8'h02);
        wr(A_MSK, 8'h3f);
        wr(A_REQ, 8'h00);
        // Full grant of the 16-bit timer request with a slow core
        wr(A_MSK, 8'h88);
        ev <= 7'h10;
        @(posedge pclk);
        ev <= 7'h00;
        repeat (2) @(posedge pclk);
        chk("timer request", core_request, 1'b1);
        chk("timer vector", vec, 8'h06);
        ack_en <= 1'b1;
        for (int n = 0; n < 40 && core_request === 1'b1; n++)
            @(posedge pclk);
        ack_en <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("granted", core_request, 1'b0);
        rdc("service clears", A_REQ, 8'h00);
        rdc("global cleared", A_MSK, 8'h08);
        rdc("event status", A_EST, 8'h08);
        chk("irq masked", irq, 1'b0);
        wr(A_EMK, 8'h08);
        chk("irq raised", irq, 1'b1);
        wr(A_EST, 8'h08);
        chk("irq cleared", irq, 1'b0);
        rdc("status cleared", A_EST, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
